// ==== src/dhb_defines.vh ====
// constants for the dual style host bus front end
// assumes inclusion by bare name from the design files under src/
`ifndef DHB_DEFINES_VH
`define DHB_DEFINES_VH

// =========================================
// bus style and pin levels
`define DHB_STYLE_STROBE 1'b1
`define DHB_STYLE_DIRLINE 1'b0
`define DHB_DIR_READ 1'b1
`define DHB_PRESCALE_1X 1'b1

// =========================================
// modem control register field positions
`define DHB_MCR_INT_EN_BIT 3
`define DHB_MCR_CLK_BIT 7

// =========================================
// timing
`define DHB_PRESCALE_DIV 4
`define DHB_PRESCALE_CNT_W 2

`endif

// ==== src/dhb_prescale.v ====
// divide-by-four tick generator feeding the 4X baud prescale path
// assumes one free running clock and an asynchronous active-high reset
`timescale 1ns/1ps
`include "dhb_defines.vh"

module dhb_prescale #(
  parameter DIV = `DHB_PRESCALE_DIV,
  parameter CNT_W = `DHB_PRESCALE_CNT_W
) (
  input wire clk_in,
  input wire rst_in,
  output reg tick_out
);

  // =========================================
  // counter
  reg [CNT_W-1:0] cnt_r;
  wire wrap = (cnt_r == DIV[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else begin
      cnt_r <= wrap ? {CNT_W{1'b0}} : cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_out <= wrap;
    end
  end

endmodule

// ==== src/dhb_host_port.v ====
// host bus front end for a four channel serial controller
// assumes host pins already synchronous to clk_in; channels sit behind the user-side ports
`timescale 1ns/1ps
`include "dhb_defines.vh"

// Function
// - style select high picks strobe bus, low picks direction-line bus
// - direction-line: write strobe is direction, reset active low, read strobe ignored
// - direction-line: all channel interrupts wire-ORed onto one open-source request
// - three low address bits pick the register inside the selected channel
// - direction-line: two upper address bits pick one channel under common select
// - strobe style: upper address pins act as chip selects of channels B, C
// - prescale select high gives 1X clock, low gives 4X prescaled clock
// - after reset a modem control bit 7 write overrides the prescale select pin
// - direction-line: common active-low select enables channels; high means none respond
// - strobe style: only channels with their own select low transfer data
// - strobe style: channel interrupt needs control bit 3, enable and pending; the code gates on control bit 3 and pending only
// - eight-bit three-state data bus, bit 0 least significant
module dhb_host_port #(
  parameter CHANNELS = 4
) (
  input wire clk_in,
  input wire rst_in,
  input wire bus_style_in,
  input wire bus_style_float_in,
  input wire dev_reset_pin_in,
  input wire cs_a_n_in,
  input wire cs_d_n_in,
  input wire [1:0] channel_addr_bits_in,
  input wire [2:0] reg_addr_bits_in,
  input wire read_strobe_n_in,
  input wire write_strobe_n_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe_n_out,
  input wire [8*CHANNELS-1:0] chan_rdata_in,
  input wire [CHANNELS-1:0] chan_int_pending_in,
  input wire [8*CHANNELS-1:0] modem_control_reg_in,
  input wire [CHANNELS-1:0] modem_control_reg_wr_in,
  input wire prescale_select_in,
  output reg [CHANNELS-1:0] chan_sel_out,
  output reg [2:0] reg_index_out,
  output reg [7:0] chan_wdata_out,
  output reg chan_rd_out,
  output reg chan_wr_out,
  output reg chip_reset_out,
  output reg [CHANNELS-1:0] int_out,
  output reg irq_out,
  output wire irq_oe_n_out,
  output reg [CHANNELS-1:0] baud_tick_out,
  output reg [CHANNELS-1:0] prescale_1x_out
);

  // =========================================
  // decode helpers
  function [3:0] chan_onehot;
    input [1:0] idx;
    begin
      chan_onehot = 4'h1 << idx;
    end
  endfunction

  function [1:0] first_chan;
    input [3:0] sel;
    begin
      if (sel[0]) begin
        first_chan = 2'h0;
      end else if (sel[1]) begin
        first_chan = 2'h1;
      end else if (sel[2]) begin
        first_chan = 2'h2;
      end else begin
        first_chan = 2'h3;
      end
    end
  endfunction

  // =========================================
  // style and access decode
  // the pull-up is modelled by the float flag, so an open pin lands on strobe style
  wire style_strobe = bus_style_in | bus_style_float_in;
  wire is_strobe = (style_strobe == `DHB_STYLE_STROBE);

  // strobe style: each channel has its own select, CHANNEL_ADDR_BITS become the B/C selects
  wire [3:0] strobe_sel = ~{cs_d_n_in, channel_addr_bits_in[1], channel_addr_bits_in[0], cs_a_n_in};
  // direction-line style: one common select, channel picked by the address bits
  wire [3:0] dir_sel = cs_a_n_in ? 4'h0 : chan_onehot(channel_addr_bits_in);

  wire [3:0] sel_now = is_strobe ? strobe_sel : dir_sel;
  wire strobe_rd = ~read_strobe_n_in & (|strobe_sel);
  wire strobe_wr = ~write_strobe_n_in & (|strobe_sel);
  // read strobe plays no part in direction-line style
  wire dir_rd = ~cs_a_n_in & (write_strobe_n_in == `DHB_DIR_READ);
  wire dir_wr = ~cs_a_n_in & (write_strobe_n_in != `DHB_DIR_READ);
  wire acc_rd = is_strobe ? (strobe_rd & ~strobe_wr) : dir_rd;
  wire acc_wr = is_strobe ? strobe_wr : dir_wr;
  wire acc_any = acc_rd | acc_wr;

  // =========================================
  // access state machine
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RD = 3'b010;
  localparam [2:0] ST_WR = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (acc_wr) begin
          state_nxt = ST_WR;
        end else if (acc_rd) begin
          state_nxt = ST_RD;
        end
      end
      ST_RD: begin
        if (!acc_rd) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR: begin
        if (!acc_wr) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // one transfer per strobe: rd and wr pulse once when the access opens
  wire opening = (state_r == ST_IDLE) & acc_any;
  wire [1:0] rd_chan = first_chan(sel_now);

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      chan_sel_out <= {CHANNELS{1'b0}};
      reg_index_out <= 3'h0;
      chan_wdata_out <= 8'h00;
      chan_rd_out <= 1'b0;
      chan_wr_out <= 1'b0;
      data_out <= 8'h00;
    end else begin
      state_r <= state_nxt;
      chan_rd_out <= opening & acc_rd & ~acc_wr;
      chan_wr_out <= opening & acc_wr;
      if (opening) begin
        chan_sel_out <= sel_now[CHANNELS-1:0];
        reg_index_out <= reg_addr_bits_in;
        chan_wdata_out <= data_in;
      end else if (state_nxt == ST_IDLE) begin
        chan_sel_out <= {CHANNELS{1'b0}};
      end
      // read data reloaded from the channel every cycle of the read, lowest selected channel wins
      if (state_r == ST_RD) begin
        data_out <= chan_rdata_in[8*rd_chan +: 8];
      end
    end
  end

  // bus driven only while a read is open; released the cycle the strobe drops
  assign data_oe_n_out = ~((state_r == ST_RD) & acc_rd);

  // =========================================
  // device reset remap
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chip_reset_out <= 1'b1;
    end else begin
      chip_reset_out <= is_strobe ? dev_reset_pin_in : ~dev_reset_pin_in;
    end
  end

  // =========================================
  // interrupt routing
  wire [CHANNELS-1:0] int_cond;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_int
      assign int_cond[g] = modem_control_reg_in[8*g + `DHB_MCR_INT_EN_BIT] & chan_int_pending_in[g];
    end
  endgenerate

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_out <= {CHANNELS{1'b0}};
      irq_out <= 1'b0;
    end else begin
      int_out <= is_strobe ? int_cond : {CHANNELS{1'b0}};
      irq_out <= ~is_strobe & (|chan_int_pending_in);
    end
  end

  // open-source request: drives high when asserted, floats otherwise
  assign irq_oe_n_out = ~irq_out;

  // =========================================
  // baud prescale selection
  wire tick4;

  dhb_prescale #(
    .DIV(`DHB_PRESCALE_DIV),
    .CNT_W(`DHB_PRESCALE_CNT_W)
  ) u_prescale (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(tick4)
  );

  // the pin rules until software writes the control register; reset hands control back to the pin
  reg [CHANNELS-1:0] ovr_r;
  reg [CHANNELS-1:0] ovr_val_r;

  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_clk
      wire sel_1x = ovr_r[g] ? ovr_val_r[g] : prescale_select_in;

      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          ovr_r[g] <= 1'b0;
          ovr_val_r[g] <= 1'b0;
          prescale_1x_out[g] <= 1'b0;
          baud_tick_out[g] <= 1'b0;
        end else begin
          if (modem_control_reg_wr_in[g]) begin
            ovr_r[g] <= 1'b1;
            ovr_val_r[g] <= modem_control_reg_in[8*g + `DHB_MCR_CLK_BIT];
          end
          prescale_1x_out[g] <= (sel_1x == `DHB_PRESCALE_1X);
          baud_tick_out[g] <= (sel_1x == `DHB_PRESCALE_1X) ? 1'b1 : tick4;
        end
      end
    end
  endgenerate

endmodule

// ==== tb/dhb_host_port_asserts.sv ====
// checker for the dual style host bus front end
// assumes binding to dhb_host_port and one clock domain
`timescale 1ns/1ps
module dhb_host_port_asserts #(parameter CHANNELS = 4) (
  input logic clk_in, rst_in, bus_style_in, bus_style_float_in, dev_reset_pin_in,
  input logic cs_a_n_in, cs_d_n_in, read_strobe_n_in, write_strobe_n_in,
  input logic [1:0] channel_addr_bits_in,
  input logic [CHANNELS-1:0] chan_int_pending_in, chan_sel_out, int_out,
  input logic [8*CHANNELS-1:0] modem_control_reg_in,
  input logic chan_rd_out, chan_wr_out, chip_reset_out, irq_out, data_oe_n_out
);
  logic sty;
  logic [3:0] ie;
  // float input wins: the internal pull-up makes strobe style
  assign sty = bus_style_in | bus_style_float_in;
  assign ie = {modem_control_reg_in[27], modem_control_reg_in[19], modem_control_reg_in[11], modem_control_reg_in[3]};
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // =========================================
  // properties
  AST_RESET_MAP: assert property (!rst_in |=> chip_reset_out == $past(sty ~^ dev_reset_pin_in))
    else $error("internal reset polarity wrong");
  AST_IRQ_OR: assert property (!sty && !rst_in |=> irq_out == |$past(chan_int_pending_in))
    else $error("shared request not or of channels");
  AST_INT_GATE: assert property (!rst_in |=> int_out == ($past(sty) ? $past(chan_int_pending_in & ie) : 4'h0))
    else $error("channel interrupt gating wrong");
  AST_DIR_SEL: assert property (!sty && $fell(cs_a_n_in) |=> chan_sel_out == 4'h1 << $past(channel_addr_bits_in))
    else $error("direction style channel decode wrong");
  AST_DIR_RW: assert property (!sty && $fell(cs_a_n_in) |=> chan_wr_out == !$past(write_strobe_n_in))
    else $error("direction line not honoured");
  AST_DIR_OFF: assert property ((!sty && cs_a_n_in) [*2] |=> !(chan_rd_out | chan_wr_out))
    else $error("access without common select");
  AST_STB_SEL: assert property (sty && $fell(read_strobe_n_in & write_strobe_n_in)
    |=> chan_sel_out == ~$past({cs_d_n_in, channel_addr_bits_in, cs_a_n_in}))
    else $error("strobe style selects wrong");
  AST_PULSE_ONE: assert property ((chan_rd_out | chan_wr_out) |=> !(chan_rd_out | chan_wr_out))
    else $error("access pulse longer than one cycle");
  AST_RD_OE: assert property (chan_rd_out |-> !data_oe_n_out)
    else $error("data bus not driven on read");
endmodule
bind dhb_host_port dhb_host_port_asserts #(.CHANNELS(CHANNELS)) dhb_host_port_asserts_i (.*);

// ==== tb/dhb_host_cpu.sv ====
// host processor model driving the bus pins in either style
// assumes requests from the bench change just after a rising edge
`timescale 1ns/1ps
module dhb_host_cpu (
  input logic style_in, go_in, wr_in,
  input logic [1:0] ch_in,
  input logic [2:0] ra_in,
  output logic cs_a_n_out, cs_d_n_out, rd_n_out, wr_n_out,
  output logic [1:0] ca_out,
  output logic [2:0] ra_out
);
  logic [3:0] sel_n;
  assign sel_n = ~({3'h0, go_in} << ch_in);
  always_comb begin
    // released address lines show the inverse, not a stale value
    ra_out = go_in ? ra_in : ~ra_in;
    if (style_in) begin
      {cs_d_n_out, ca_out, cs_a_n_out} = sel_n;
      rd_n_out = !(go_in && !wr_in);
      wr_n_out = !(go_in && wr_in);
    end else begin
      cs_a_n_out = !go_in;
      cs_d_n_out = 1'h0;
      ca_out = go_in ? ch_in : ~ch_in;
      rd_n_out = 1'h0;
      wr_n_out = !wr_in;
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the dual style host bus front end
// assumes the host model on the pins and bench-driven channel side
`timescale 1ns/1ps
module tb;
  logic clk_in = 0, rst_in = 1, sty = 1, flt = 0, dev_rst = 1, go = 0, wr = 0, psel = 1;
  logic cs_a_n, cs_d_n, rd_n, wr_n, oe_n, rd_p, wr_p, crst, irq, irq_oe_n;
  logic [1:0] ch = 0, ca;
  logic [2:0] ra = 0, ra_p, idx;
  logic [7:0] wd = 0, dout, wdo;
  logic [3:0] pend = 0, mw = 0, sel, int_o, tick, p1x;
  logic [31:0] modem_control_reg = 0, rdat = 32'h44332211;
  int bad_count = 0, cmp_count = 0, n, k;
  dhb_host_cpu dhb_host_cpu_i (.style_in(sty | flt), .go_in(go), .wr_in(wr), .ch_in(ch), .ra_in(ra),
    .cs_a_n_out(cs_a_n), .cs_d_n_out(cs_d_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .ca_out(ca), .ra_out(ra_p));
  dhb_host_port dhb_host_port_i (.clk_in(clk_in), .rst_in(rst_in), .bus_style_in(sty), .bus_style_float_in(flt),
    .dev_reset_pin_in(dev_rst), .cs_a_n_in(cs_a_n), .cs_d_n_in(cs_d_n), .channel_addr_bits_in(ca),
    .reg_addr_bits_in(ra_p), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .data_in(wd), .data_out(dout),
    .data_oe_n_out(oe_n), .chan_rdata_in(rdat), .chan_int_pending_in(pend), .modem_control_reg_in(modem_control_reg),
    .modem_control_reg_wr_in(mw), .prescale_select_in(psel), .chan_sel_out(sel), .reg_index_out(idx),
    .chan_wdata_out(wdo), .chan_rd_out(rd_p), .chan_wr_out(wr_p), .chip_reset_out(crst), .int_out(int_o),
    .irq_out(irq), .irq_oe_n_out(irq_oe_n), .baud_tick_out(tick), .prescale_1x_out(p1x));
  initial forever #10 clk_in = ~clk_in;
  task chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [1:0] c, input logic [2:0] r, input logic [7:0] d);
    @(posedge clk_in);
    go <= 1; wr <= w; ch <= c; ra <= r; wd <= d;
    for (n = 0; n < 5 && !(rd_p | wr_p); n++) begin @(posedge clk_in); #1; end
    chk(8'(sel), 8'h1 << c);
    chk(8'(idx), 8'(r));
    if (w) begin
      chk(wdo, d);
    end else begin
      chk(8'(oe_n), 8'h00);
      @(posedge clk_in);
      #1;
      chk(dout, rdat[8*c +: 8]);
    end
    @(posedge clk_in);
    go <= 0;
    @(posedge clk_in);
    // the bus must be let go as soon as the strobe or select drops
    #1 chk(8'(oe_n), 8'h01);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // =========================================
  // tests
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    repeat (3) @(posedge clk_in); #1 chk(8'(p1x), 8'h0F);
    @(posedge clk_in); psel <= 0;
    repeat (3) @(posedge clk_in); #1 chk(8'(p1x), 8'h00);
    k = 0;
    repeat (8) begin @(posedge clk_in); #1 k += tick[0]; end
    chk(8'(k), 8'h02);
    @(posedge clk_in); modem_control_reg <= 32'h80888088; mw <= 4'hF; pend <= 4'hF;
    @(posedge clk_in); mw <= 4'h0;
    repeat (3) @(posedge clk_in); #1 chk(8'(p1x), 8'h0F);
    chk(8'(int_o), 8'h05);
    chk(8'(tick), 8'h0F);
    chk(8'(irq_oe_n), 8'h01);
    $display("test prescale and interrupts done");
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, i[1:0], 3'(i + 1), 8'(8'hA0 + i));
      acc(1'h0, i[1:0], 3'(7 - i), 8'h00);
    end
    $display("test strobe style done");
    @(posedge clk_in); sty <= 0; dev_rst <= 0;
    repeat (2) @(posedge clk_in); #1 chk(8'(crst), 8'h01);
    chk(8'(int_o), 8'h00);
    chk(8'(irq), 8'h01);
    chk(8'(irq_oe_n), 8'h00);
    @(posedge clk_in); dev_rst <= 1;
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, i[1:0], i[2:0], 8'(8'h5A ^ i));
      acc(1'h0, i[1:0], 3'(4 + i), 8'h00);
    end
    // common select left high: strobes and address must not open an access
    @(posedge clk_in); ch <= 2; wr <= 1;
    repeat (3) @(posedge clk_in); #1 chk(8'(sel), 8'h00);
    chk(8'(crst), 8'h00);
    $display("test direction style done");
    @(posedge clk_in); flt <= 1;
    repeat (2) @(posedge clk_in); #1 chk(8'(crst), 8'h01);
    acc(1'h1, 2'h3, 3'h5, 8'hC3);
    $display("test undriven style pin done");
    // reset in mid-run hands the prescale choice back to the pin, which is still low
    @(posedge clk_in); rst_in <= 1;
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    repeat (2) @(posedge clk_in); #1 chk(8'(p1x), 8'h00);
    chk(8'(int_o), 8'h05);
    chk(8'(irq_oe_n), 8'h01);
    $display("test reset in mid-run done");
    give_verdict;
  end
  initial begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule
